/* File: src/hop_table_sequencer.sv */
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Two tables A and B, one to sixty-four entries each.
// - Entry holds frequency, two rx offsets, two rx gains, two tx attens.
// - Only rx or tx parameters of the entry reach the outputs per frame.
// - Auto increment starts at 0, steps per hop edge, wraps at count.
// - An entry is read on every hop edge, rising and falling, except an edge that switches tables by pin or command or samples an out-of-range pin index.
// - Pin mode forms index from up to six pins at each hop edge.
// - Lowest index pin is the index LSB.
// - Any valid sampled index is used; controller keeps indices in range.
// - Any table change resets the index to 0.
// - A newly selected table is first read at the next hop edge.
// - Ping-pong switches table after the last entry without any pin.
// - Manual switching by software command or table-select pin.
// - Select low means table A, high means table B.
// - Table-select is sampled at hop edges; controller settles it first.
// - Pin indexing disables ping-pong switching.
// - Pre-process mode refuses table writes while hopping.
// - Real-time mode allows table writes during hopping.
module hop_table_sequencer import hop_pkg::*; #(
	parameter int DEPTH = TABLE_DEPTH,
	parameter int IDX_W = INDEX_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hsel,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic hop_pin,
	input wire logic rx_setup,
	input wire logic tx_setup,
	input wire logic [IDX_W-1:0] index_pins,
	input wire logic table_select_pin,
	output logic [FREQ_W-1:0] entry_frequency,
	output logic [FREQ_W-1:0] rx_first_offset_freq,
	output logic [FREQ_W-1:0] rx_second_offset_freq,
	output logic [GAIN_W-1:0] rx_first_start_gain,
	output logic [GAIN_W-1:0] rx_second_start_gain,
	output logic [ATTEN_W-1:0] tx_first_start_atten,
	output logic [ATTEN_W-1:0] tx_second_start_atten,
	output logic frame_is_tx,
	output logic hop_strobe,
	output logic out_of_range
);

	// Six index pins at most, and a table may not outgrow its index space.
	if (DEPTH < 1 || DEPTH > (1 << IDX_W) || IDX_W > 6) begin : g_bad_params
		$error("hop_table_sequencer: unsupported depth or index width");
	end

	typedef logic [IDX_W:0] addr_t;
	localparam int MEM_W = 3 * FREQ_W + 2 * GAIN_W + 2 * ATTEN_W;
	localparam int MEM_D = 2 << IDX_W;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [6:0] count_a;
		logic [6:0] count_b;
		logic [31:0] ld_addr;
		logic [31:0] ld_freq;
		logic [31:0] ld_ofs1;
		logic [31:0] ld_ofs2;
		logic [31:0] ld_gain;
		logic [31:0] ld_atten;
		logic wr_pend;
		logic [7:0] wr_ofs;
		logic rd_valid;
		logic [31:0] rdata;
		logic hop_q;
		logic rx_q;
		logic tx_q;
		logic dir_tx;
		logic dir_next;
		logic sel_b;
		logic sel_q;
		logic sw_req;
		logic fresh;
		logic [IDX_W-1:0] idx;
		logic mem_we;
		logic rd_req;
		addr_t rd_addr;
		logic rd_tx;
		logic strobe;
		logic oor;
		logic [MEM_W-1:0] out_word;
		logic out_tx;
	} state_s;

	state_s s_reg, s_next;
	logic [MEM_W-1:0] mem [MEM_D];
	logic [MEM_W-1:0] mem_q;
	logic [MEM_W-1:0] ld_word;
	addr_t wr_addr;

	function automatic addr_t entry_addr(input logic b, input logic [IDX_W-1:0] i);
		entry_addr = {b, i};
	endfunction

	function automatic logic [6:0] tbl_count(input state_s s, input logic b);
		tbl_count = b ? s.count_b : s.count_a;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Table storage: one array holds both tables, the select bit on top.
	assign ld_word = {s_reg.ld_freq, s_reg.ld_ofs1, s_reg.ld_ofs2,
		s_reg.ld_gain[15:0], s_reg.ld_atten};
	assign wr_addr = addr_t'(s_reg.ld_addr);

	always_ff @(posedge ref_clk) begin
		if (s_reg.mem_we)
			mem[wr_addr] <= ld_word;
		// Looking up the next address hides the array latency behind the
		// request cycle, so the captured word is never the previous entry.
		mem_q <= mem[s_next.rd_addr];
	end

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic hop_edge;
		logic switch_now;
		logic new_b;
		logic [6:0] cnt;
		logic pin_mode;
		logic busy_wr;
		hop_edge = 1'b0;
		switch_now = 1'b0;
		new_b = 1'b0;
		cnt = 7'h00;
		pin_mode = 1'b0;
		busy_wr = 1'b0;
		s_next = s_reg;
		s_next.mem_we = 1'b0;
		s_next.rd_req = 1'b0;
		s_next.strobe = 1'b0;
		s_next.rd_valid = 1'b0;
		s_next.hop_q = hop_pin;
		s_next.rx_q = rx_setup;
		s_next.tx_q = tx_setup;
		pin_mode = s_reg.ctrl[CTRL_PIN_IDX_BIT];
		// Setup pins name the direction of the coming frame.
		if (rx_setup && !s_reg.rx_q)
			s_next.dir_next = 1'b0;
		if (tx_setup && !s_reg.tx_q)
			s_next.dir_next = 1'b1;

		// Bus write data phase lands here.
		if (s_reg.wr_pend) begin
			s_next.wr_pend = 1'b0;
			unique case (s_reg.wr_ofs)
				CTRL_OFS: s_next.ctrl = hwdata;
				COUNT_OFS: begin
					s_next.count_a = hwdata[6:0];
					s_next.count_b = hwdata[22:16];
				end
				ADDR_OFS: s_next.ld_addr = hwdata;
				FREQ_OFS: s_next.ld_freq = hwdata;
				RXOFS1_OFS: s_next.ld_ofs1 = hwdata;
				RXOFS2_OFS: s_next.ld_ofs2 = hwdata;
				GAIN_OFS: s_next.ld_gain = hwdata;
				ATTEN_OFS: begin
					s_next.ld_atten = hwdata;
					busy_wr = s_reg.ctrl[CTRL_EN_BIT] &&
						!s_reg.ctrl[CTRL_REALTIME_BIT];
					s_next.mem_we = !busy_wr;
				end
				CMD_OFS: begin
					if (hwdata[CMD_SEL_BIT] != s_reg.sel_b)
						s_next.sw_req = 1'b1;
					if (hwdata[CMD_CLR_OOR_BIT])
						s_next.oor = 1'b0;
				end
				default: ;
			endcase
		end

		// Address phase.
		if (hsel && hready && htrans[1]) begin
			if (hwrite) begin
				s_next.wr_pend = 1'b1;
				s_next.wr_ofs = haddr[7:0];
			end else begin
				s_next.rd_valid = 1'b1;
				unique case (haddr[7:0])
					CTRL_OFS: s_next.rdata = s_reg.ctrl;
					COUNT_OFS: s_next.rdata = {9'h000, s_reg.count_b,
						9'h000, s_reg.count_a};
					STATUS_OFS: s_next.rdata = 32'({s_reg.idx, 7'h00,
						s_reg.oor, s_reg.dir_tx, s_reg.sel_b,
						6'h00});
					ADDR_OFS: s_next.rdata = s_reg.ld_addr;
					default: s_next.rdata = 32'h0000_0000;
				endcase
			end
		end

		// Hop edge handling.
		// Any level change against the previous cycle is one hop edge.
		hop_edge = s_reg.ctrl[CTRL_EN_BIT] &&
			(hop_pin != s_reg.hop_q);
		if (hop_edge) begin
			s_next.sel_q = table_select_pin;
			new_b = s_reg.sel_b;
			if (s_reg.ctrl[CTRL_PIN_SEL_BIT] &&
				table_select_pin != s_reg.sel_b) begin
				switch_now = 1'b1;
				new_b = table_select_pin;
			end
			if (s_reg.sw_req) begin
				switch_now = 1'b1;
				new_b = !s_reg.sel_b;
			end
			s_next.sw_req = 1'b0;
			s_next.dir_tx = s_reg.dir_next;
			if (switch_now) begin
				// Switch only arms the table; next edge reads entry 0, or the pin index in pin mode.
				s_next.sel_b = new_b;
				s_next.idx = '0;
				s_next.fresh = 1'b1;
			end else if (pin_mode) begin
				cnt = tbl_count(s_reg, s_reg.sel_b);
				if ({1'b0, index_pins} < cnt) begin
					s_next.idx = index_pins;
					s_next.rd_req = 1'b1;
				end else begin
					s_next.oor = 1'b1;
				end
			end else begin
				cnt = tbl_count(s_reg, s_reg.sel_b);
				s_next.rd_req = 1'b1;
				s_next.rd_addr = entry_addr(s_reg.sel_b, s_reg.idx);
				s_next.fresh = 1'b0;
				if (7'(s_reg.idx) + 7'h01 >= cnt) begin
					s_next.idx = '0;
					if (s_reg.ctrl[CTRL_PINGPONG_BIT] && !pin_mode) begin
						s_next.sel_b = !s_reg.sel_b;
						s_next.fresh = 1'b1;
					end
				end else begin
					s_next.idx = s_reg.idx + 1'b1;
				end
			end
			if (pin_mode && !switch_now)
				s_next.rd_addr = entry_addr(s_reg.sel_b, index_pins);
			s_next.rd_tx = s_reg.dir_next;
		end
		if (!s_reg.ctrl[CTRL_EN_BIT]) begin
			s_next.idx = '0;
			s_next.sel_b = 1'b0;
		end

		// Memory answers one cycle after the request.
		if (s_reg.rd_req) begin
			s_next.strobe = 1'b1;
			s_next.out_tx = s_reg.rd_tx;
			s_next.out_word = mem_q;
			// Fields of the other direction are dropped at capture, so each
			// entry output is a bare register slice.
			if (s_reg.rd_tx)
				s_next.out_word[MEM_W-FREQ_W-1:2*ATTEN_W] = '0;
			else
				s_next.out_word[2*ATTEN_W-1:0] = '0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.ctrl <= CTRL_RST;
			s_reg.count_a <= COUNT_RST;
			s_reg.count_b <= COUNT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Only the fields of the frame direction carry values; others read zero.
	// Zeroing rather than holding keeps stale values off the idle path.
	assign entry_frequency = s_reg.out_word[MEM_W-1 -: FREQ_W];
	assign rx_first_offset_freq =
		s_reg.out_word[MEM_W-FREQ_W-1 -: FREQ_W];
	assign rx_second_offset_freq =
		s_reg.out_word[MEM_W-2*FREQ_W-1 -: FREQ_W];
	assign rx_first_start_gain =
		s_reg.out_word[2*ATTEN_W+GAIN_W +: GAIN_W];
	assign rx_second_start_gain =
		s_reg.out_word[2*ATTEN_W +: GAIN_W];
	assign tx_first_start_atten =
		s_reg.out_word[ATTEN_W +: ATTEN_W];
	assign tx_second_start_atten =
		s_reg.out_word[0 +: ATTEN_W];
	assign frame_is_tx = s_reg.out_tx;
	assign hop_strobe = s_reg.strobe;
	assign out_of_range = s_reg.oor;
	assign hrdata = s_reg.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	//////////////////////////////////////////////////////////////////////////
	chk_strobe_follows_hop: assert property (@(posedge ref_clk) disable iff (rst)
		(s_reg.ctrl[CTRL_EN_BIT] && hop_pin != s_reg.hop_q &&
		!s_reg.sw_req && !s_reg.ctrl[CTRL_PIN_SEL_BIT] &&
		!s_reg.ctrl[CTRL_PIN_IDX_BIT]) |-> ##2 hop_strobe)
		else $error("no entry read after hop edge");
	chk_switch_zero_idx: assert property (@(posedge ref_clk) disable iff (rst)
		$changed(s_reg.sel_b) |-> s_reg.idx == '0)
		else $error("index not zero after table switch");
	chk_wrap_bound: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.rd_req && !s_reg.ctrl[CTRL_PIN_IDX_BIT] |->
		7'(s_reg.rd_addr[IDX_W-1:0]) < tbl_count(s_reg, s_reg.rd_addr[IDX_W]))
		else $error("auto index beyond count");
	chk_tx_rx_gate: assert property (@(posedge ref_clk) disable iff (rst)
		frame_is_tx |-> rx_first_start_gain == '0 && rx_first_offset_freq == '0)
		else $error("rx fields leak into tx frame");
	chk_no_pingpong_pin: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.ctrl[CTRL_PIN_IDX_BIT] && !s_reg.ctrl[CTRL_PIN_SEL_BIT] &&
		!s_reg.sw_req && s_reg.ctrl[CTRL_EN_BIT] && $past(s_reg.ctrl[CTRL_EN_BIT])
		|=> $stable(s_reg.sel_b))
		else $error("ping-pong in pin index mode");
	chk_preproc_lock: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.ctrl[CTRL_EN_BIT] && !s_reg.ctrl[CTRL_REALTIME_BIT] |=>
		!s_reg.mem_we || $past(!s_reg.ctrl[CTRL_EN_BIT]))
		else $error("table written while hopping");
	chk_oor_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		out_of_range && !(s_reg.wr_pend && s_reg.wr_ofs == CMD_OFS) |=> out_of_range)
		else $error("out-of-range flag lost");
	chk_pin_select: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.ctrl[CTRL_EN_BIT] && s_reg.ctrl[CTRL_PIN_SEL_BIT] &&
		hop_pin != s_reg.hop_q && !s_reg.sw_req |=>
		s_reg.sel_b == $past(table_select_pin))
		else $error("select pin not followed");
endmodule // hop_table_sequencer

/* File: src/hop_pkg.sv */
package hop_pkg;
	localparam int TABLE_DEPTH = 64;
	localparam int INDEX_W = 6;
	localparam int FREQ_W = 32;
	localparam int GAIN_W = 8;
	localparam int ATTEN_W = 16;
	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] COUNT_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] ADDR_OFS = 8'h0C;
	localparam logic [7:0] FREQ_OFS = 8'h10;
	localparam logic [7:0] RXOFS1_OFS = 8'h14;
	localparam logic [7:0] RXOFS2_OFS = 8'h18;
	localparam logic [7:0] GAIN_OFS = 8'h1C;
	localparam logic [7:0] ATTEN_OFS = 8'h20;
	localparam logic [7:0] CMD_OFS = 8'h24;
	// Control fields.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PIN_IDX_BIT = 1;
	localparam int CTRL_PINGPONG_BIT = 2;
	localparam int CTRL_PIN_SEL_BIT = 3;
	localparam int CTRL_REALTIME_BIT = 4;
	localparam int CTRL_NPINS_LSB = 8;
	localparam int CMD_SEL_BIT = 0;
	localparam int CMD_CLR_OOR_BIT = 1;
	localparam logic [6:0] COUNT_RST = 7'h01;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage

/* File: bench/hop_controller_model.sv */
`timescale 1ns/1ps
// Baseband side: setup pulse, index and select first, then the hop edge.
module hop_controller_model import hop_pkg::*; (
	input wire logic ref_clk,
	output logic hop_pin,
	output logic rx_setup,
	output logic tx_setup,
	output logic [INDEX_W-1:0] index_pins,
	output logic table_select_pin
);
	initial begin
		hop_pin = 1'b0;
		rx_setup = 1'b0;
		tx_setup = 1'b0;
		index_pins = '0;
		table_select_pin = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Pins settle two cycles ahead so the device never samples a changing
	// index or select level at the hop edge.
	task automatic hop(input logic tx, input logic [INDEX_W-1:0] idx,
		input logic sel);
		@(posedge ref_clk);
		index_pins <= idx;
		table_select_pin <= sel;
		rx_setup <= !tx;
		tx_setup <= tx;
		repeat (2) @(posedge ref_clk);
		hop_pin <= !hop_pin;
		@(posedge ref_clk);
		rx_setup <= 1'b0;
		tx_setup <= 1'b0;
	endtask
endmodule // hop_controller_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench import hop_pkg::*; ;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic hsel = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hrdata, rd, e0, e1, e2, rf0, rf1, rf2, rd_freq;
	logic [31:0] rx_first_offset_freq, rx_second_offset_freq;
	logic [7:0] rx_first_start_gain, rx_second_start_gain;
	logic [15:0] tx_first_start_atten, tx_second_start_atten;
	logic hreadyout, hresp, hop_pin, rx_setup, tx_setup, table_select_pin;
	logic frame_is_tx, hop_strobe, out_of_range, dir_tx = 1'b0;
	logic [INDEX_W-1:0] index_pins;
	int errors = 0;
	int tests_run = 0;
	always #2.5 ref_clk = ~ref_clk;
	hop_table_sequencer u_hop_table_sequencer (.ref_clk(ref_clk), .rst(rst),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .hop_pin(hop_pin),
		.rx_setup(rx_setup), .tx_setup(tx_setup), .index_pins(index_pins),
		.table_select_pin(table_select_pin), .entry_frequency(rd_freq),
		.rx_first_offset_freq(rx_first_offset_freq),
		.rx_second_offset_freq(rx_second_offset_freq),
		.rx_first_start_gain(rx_first_start_gain),
		.rx_second_start_gain(rx_second_start_gain),
		.tx_first_start_atten(tx_first_start_atten),
		.tx_second_start_atten(tx_second_start_atten),
		.frame_is_tx(frame_is_tx), .hop_strobe(hop_strobe),
		.out_of_range(out_of_range));
	hop_controller_model u_hop_controller_model (.ref_clk(ref_clk),
		.hop_pin(hop_pin), .rx_setup(rx_setup), .tx_setup(tx_setup),
		.index_pins(index_pins), .table_select_pin(table_select_pin));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			finish_test();
		end
	endtask
	// Single word transfers; the address phase is held until hready.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsel <= 1'b1;
		wait_rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	// Offsets and first atten derive from the frequency so a wrong entry shows; gains and second atten are fixed.
	task automatic load(input logic sel, input int i, input logic [31:0] f);
		bus(1'b1, ADDR_OFS, {25'h0, sel, 6'(i)});
		bus(1'b1, FREQ_OFS, f);
		bus(1'b1, RXOFS1_OFS, f + 32'h1);
		bus(1'b1, RXOFS2_OFS, f + 32'h2);
		bus(1'b1, GAIN_OFS, 32'h0000_5A3C);
		bus(1'b1, ATTEN_OFS, {f[15:0], 16'h0077});
	endtask
	task automatic hop(input int idx, input logic sel, input logic rdx,
		input logic [31:0] f);
		logic seen;
		seen = 1'b0;
		u_hop_controller_model.hop(dir_tx, 6'(idx), sel);
		repeat (8) begin
			@(negedge ref_clk);
			if (hop_strobe === 1'b1) seen = 1'b1;
		end
		check("hop_strobe", seen, rdx);
		check("entry_frequency", rd_freq, f);
		if (rdx) begin
			check("frame_is_tx", frame_is_tx, dir_tx);
			check("rx_ofs1", rx_first_offset_freq, dir_tx ? 0 : f + 1);
			check("rx_gain2", rx_second_start_gain, dir_tx ? 0 : 8'h3C);
			check("rx_ofs2", rx_second_offset_freq, dir_tx ? 0 : f + 2);
			check("rx_gain1", rx_first_start_gain, dir_tx ? 0 : 8'h5A);
			check("tx_att1", tx_first_start_atten, dir_tx ? f[15:0] : 0);
			check("tx_att2", tx_second_start_atten, dir_tx ? 16'h77 : 0);
			dir_tx = !dir_tx;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		e0 = 32'h1000; e1 = 32'h1001; e2 = 32'h1002;
		rf0 = 32'h2000; rf1 = 32'h2001; rf2 = 32'h1AAA;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		bus(1'b0, COUNT_OFS, 0);
		check("count", rd, {9'h0, COUNT_RST, 9'h0, COUNT_RST});
		bus(1'b0, 8'h40, 0);
		check("unmapped", rd, 32'h0);
		for (int i = 0; i < 3; i++) load(1'b0, i, e0 + i);
		for (int i = 0; i < 2; i++) load(1'b1, i, rf0 + i);
		bus(1'b1, COUNT_OFS, 32'h0002_0003);
		bus(1'b1, CTRL_OFS, 32'h1);
		hop(0, 0, 1, e0); hop(0, 0, 1, e1); hop(0, 0, 1, e2);
		hop(0, 0, 1, e0);
		$display("test auto_increment done");
		bus(1'b1, CTRL_OFS, 0);
		bus(1'b1, CTRL_OFS, 32'h5);
		hop(0, 0, 1, e0); hop(0, 0, 1, e1); hop(0, 0, 1, e2);
		hop(0, 0, 1, rf0); hop(0, 0, 1, rf1); hop(0, 0, 1, e0);
		$display("test ping_pong done");
		bus(1'b1, CTRL_OFS, 0);
		bus(1'b1, CTRL_OFS, 32'h0607);
		hop(2, 0, 1, e2); hop(1, 0, 1, e1);
		hop(5, 0, 0, e1);
		bus(1'b0, STATUS_OFS, 0);
		check("oor", rd[8], 1'b1);
		check("out_of_range", out_of_range, 1'b1);
		hop(0, 0, 1, e0);
		bus(1'b1, CMD_OFS, 32'h2);
		bus(1'b0, STATUS_OFS, 0);
		check("oor_clear", {rd[8], rd[6]}, 2'b00);
		check("out_of_range_clear", out_of_range, 1'b0);
		$display("test pin_index done");
		bus(1'b1, CTRL_OFS, 0);
		bus(1'b1, CTRL_OFS, 32'h9);
		hop(0, 0, 1, e0); hop(0, 0, 1, e1); hop(0, 1, 0, e1);
		hop(0, 1, 1, rf0); hop(0, 1, 1, rf1); hop(0, 1, 1, rf0);
		hop(0, 0, 0, rf0); hop(0, 0, 1, e0);
		$display("test select_pin done");
		bus(1'b1, CTRL_OFS, 0);
		bus(1'b1, CTRL_OFS, 32'h1);
		load(1'b0, 0, 32'h1FFF);
		hop(0, 0, 1, e0);
		bus(1'b1, CTRL_OFS, 0);
		bus(1'b1, CTRL_OFS, 32'h11);
		load(1'b0, 0, rf2);
		hop(0, 0, 1, rf2);
		$display("test table_update done");
		bus(1'b1, CMD_OFS, 32'h1);
		hop(0, 0, 0, rf2); hop(0, 0, 1, rf0);
		bus(1'b0, STATUS_OFS, 0);
		check("sel", rd[6], 1'b1);
		$display("test software_switch done");
		finish_test();
	end
endmodule // testbench
